// File: core/uic_pkg.sv
// constants shared by the button and led controller
package uic_pkg;
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_MS = 1;
  localparam int TICK_DIV = TICK_NS / CLK_NS;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_T = HOLD_MS / TICK_MS;
  localparam int WAKE_PWR_S = 10;
  localparam int WAKE_PWR_T = WAKE_PWR_S * 1000 / TICK_MS;
  localparam int WAKE_WL_MIN = 2;
  localparam int WAKE_WL_T = WAKE_WL_MIN * 60000 / TICK_MS;
  localparam int SEC_T = 1000 / TICK_MS;
  localparam int CHG_SEQ_MS = 3000;
  localparam int CHG_SEQ_T = CHG_SEQ_MS / TICK_MS;
  localparam int CHG_STEP_MS = 250;
  localparam int CHG_STEP_T = CHG_STEP_MS / TICK_MS;
  // blink table: 1 s even, power sleep normal, power sleep emergency,
  // battery slow, battery low
  localparam int BLK_N = 5;
  localparam int BLK_PER_MS [BLK_N] = '{1000, 5000, 2500, 1500, 1125};
  localparam int BLK_ON_MS [BLK_N] = '{500, 125, 125, 1250, 125};
  localparam int BLK_EVEN = 0;
  localparam int BLK_SLP = 1;
  localparam int BLK_SLP_EM = 2;
  localparam int BLK_BAT = 3;
  localparam int BLK_BAT_LO = 4;
  // led positions
  localparam int LED_PWR = 0;
  localparam int LED_BAT = 1;
  localparam int LED_POS = 2;
  localparam int LED_WL = 3;
  localparam int LED_REP = 4;
  localparam int LED_SIG = 5;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [5:0] CTRL_RST = 6'h3F;
  localparam logic [15:0] RATE_RST = 16'h012C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // status encodings
  localparam logic [1:0] BAT_REQ = 2'h0;
  localparam logic [1:0] BAT_LT20 = 2'h1;
  localparam logic [1:0] BAT_LT80 = 2'h2;
  localparam logic [1:0] FIX_3D = 2'h3;
  localparam logic [1:0] REP_FAIL = 2'h1;
  localparam logic [1:0] REP_OK = 2'h2;
  localparam logic [2:0] BARS_SOLID = 3'h3;
  typedef enum logic [1:0] {UIC_OFF, UIC_SLEEP, UIC_AWAKE} uic_pwr_t;
endpackage : uic_pkg

// File: core/uic_btn_if.sv
// button event carrier between button qualifier and controller
`timescale 1ns/100ps
interface uic_btn_if;
  logic short_p;
  logic long_p;
  modport src (output short_p, output long_p);
  modport dst (input short_p, input long_p);
endinterface : uic_btn_if

// File: core/uic_tick.sv
// millisecond tick divider
`timescale 1ns/100ps
module uic_tick #(
  parameter int DIV = uic_pkg::TICK_DIV
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic tick
);
  logic [$clog2(DIV)-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == ($clog2(DIV))'(DIV - 1));
      if (cnt_r == ($clog2(DIV))'(DIV - 1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : uic_tick

// File: core/uic_btn.sv
// button synchroniser and short or long press classifier
`timescale 1ns/100ps
module uic_btn #(
  parameter int HOLD = uic_pkg::HOLD_T
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic btn_n,
  uic_btn_if.src ev
);
  logic s1_r, s2_r, s3_r, down_r;
  logic [$clog2(HOLD+1)-1:0] held_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= btn_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // press level changes only when stages two and three agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      down_r <= 1'b0;
      held_r <= '0;
      ev.short_p <= 1'b0;
      ev.long_p <= 1'b0;
    end else begin
      ev.short_p <= 1'b0;
      ev.long_p <= 1'b0;
      if (s2_r == s3_r) begin
        down_r <= !s3_r;
      end
      if (down_r && (s2_r == s3_r) && s3_r) begin
        ev.long_p <= (held_r == ($clog2(HOLD+1))'(HOLD));
        ev.short_p <= (held_r != ($clog2(HOLD+1))'(HOLD));
        held_r <= '0;
      end else if (down_r && tick &&
                   held_r != ($clog2(HOLD+1))'(HOLD)) begin
        held_r <= held_r + 1'b1;
      end
    end
  end
endmodule : uic_btn

// File: core/uic_top.sv
// button and status led controller with axi4-lite registers
// Notes on behaviour
// - power held two seconds then released toggles off and on
// - brief power press while sleeping wakes device for ten seconds
// - each two-second wireless press while awake toggles the wireless link
// - wireless press while sleeping wakes device for two minutes
// - power, wireless, power, wireless presses enter emergency, on or off
// - emergency entry reports at once, then repeats at configured rate
// - outgoing messages carry emergency flag while emergency is active
// - power off clears emergency until sequence is repeated
// - awake emergency outside the charger chase blinks all six led_enable_setting together, half second each
// - sleeping in emergency stops six-led pattern, power blink remains
// - power led off, solid awake, sleep blink every 5 s or 2.5 s
// - battery led shows level and charge progress with fixed blinks
// - position led off, blinking for 2-d fix, solid for 3-d fix
// - wireless led off, one-second blink unconnected, solid connected
// - report led off, blink on failed report, solid on success
// - signal led off, blink one or two bars, solid three to five
// - external power while on runs four-led clockwise chase 3 s
// - after special patterns every led returns to normal status
// - each led has its own enable; disabled led stays dark
// - no led is driven while powered off, even when charging
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module uic_top #(
  parameter int TICK_DIV = uic_pkg::TICK_DIV
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic pwr_btn_n,
  input wire logic wireless_link_button_n,
  input wire logic [1:0] battery_indicator_level,
  input wire logic charging,
  input wire logic charge_done,
  input wire logic ext_power,
  input wire logic [1:0] fix_kind,
  input wire logic link_conn,
  input wire logic [1:0] report_res,
  input wire logic [2:0] signal_bars,
  input wire logic sleep_req,
  output logic [5:0] led_o,
  output logic powered_o,
  output logic awake_o,
  output logic wireless_en_o,
  output logic emerg_flag_o,
  output logic emerg_report_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int WW = $clog2(uic_pkg::WAKE_WL_T + 1);
  localparam int SW = $clog2(uic_pkg::SEC_T);
  localparam int CW = $clog2(uic_pkg::CHG_SEQ_T + 1);
  localparam int TW = $clog2(uic_pkg::CHG_STEP_T);

  logic tick;
  uic_pkg::uic_pwr_t st_r;
  logic [WW-1:0] wake_r;
  logic [1:0] seq_r;
  logic seq_done, emerg_r, link_r;
  logic [SW-1:0] sub_r;
  logic [15:0] sec_r;
  logic [5:0] led_en_r;
  logic [15:0] rate_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic ext_d_r, chg_act_r;
  logic [CW-1:0] chg_cnt_r;
  logic [TW-1:0] stp_r;
  logic [1:0] pos_r;
  logic [uic_pkg::BLK_N-1:0] ph;
  logic [5:0] led_nxt;
  logic do_wr;

  uic_btn_if pwr_ev ();
  uic_btn_if wl_ev ();

  ////////////////////////////////////////////////////////////////////////
  // time base and buttons
  uic_tick #(.DIV(TICK_DIV)) u_tick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  uic_btn u_pwr (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .btn_n(pwr_btn_n),
    .ev(pwr_ev)
  );

  uic_btn u_wl (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .btn_n(wireless_link_button_n),
    .ev(wl_ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // emergency press sequence
  assign seq_done = wl_ev.short_p && (seq_r == 2'h3);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_r <= 2'h0;
    end else if (pwr_ev.short_p) begin
      seq_r <= (seq_r == 2'h0 || seq_r == 2'h2) ? seq_r + 2'h1 : 2'h1;
    end else if (wl_ev.short_p) begin
      seq_r <= (seq_r == 2'h1) ? 2'h2 : 2'h0;
    end else if (pwr_ev.long_p || wl_ev.long_p) begin
      seq_r <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state and wake timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= uic_pkg::UIC_OFF;
      wake_r <= '0;
    end else begin
      case (st_r)
        uic_pkg::UIC_OFF: begin
          if (pwr_ev.long_p || seq_done) begin
            st_r <= uic_pkg::UIC_AWAKE;
            wake_r <= '0;
          end
        end
        uic_pkg::UIC_SLEEP: begin
          if (pwr_ev.long_p) begin
            st_r <= uic_pkg::UIC_OFF;
          end else if (wl_ev.short_p || wl_ev.long_p) begin
            st_r <= uic_pkg::UIC_AWAKE;
            wake_r <= WW'(uic_pkg::WAKE_WL_T);
          end else if (pwr_ev.short_p) begin
            st_r <= uic_pkg::UIC_AWAKE;
            wake_r <= WW'(uic_pkg::WAKE_PWR_T);
          end
        end
        uic_pkg::UIC_AWAKE: begin
          if (pwr_ev.long_p) begin
            st_r <= uic_pkg::UIC_OFF;
            wake_r <= '0;
          end else if (wake_r != '0) begin
            if (tick) begin
              wake_r <= wake_r - 1'b1;
              if (wake_r == WW'(1)) begin
                st_r <= uic_pkg::UIC_SLEEP;
              end
            end
          end else if (sleep_req) begin
            st_r <= uic_pkg::UIC_SLEEP;
          end
        end
        default: begin
          st_r <= uic_pkg::UIC_OFF;
          wake_r <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wireless link and emergency mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_r <= 1'b0;
    end else if (st_r == uic_pkg::UIC_OFF || pwr_ev.long_p) begin
      link_r <= 1'b0;
    end else if (wl_ev.long_p && st_r == uic_pkg::UIC_AWAKE) begin
      link_r <= !link_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      emerg_r <= 1'b0;
    end else if (pwr_ev.long_p && st_r != uic_pkg::UIC_OFF) begin
      emerg_r <= 1'b0;
    end else if (seq_done) begin
      emerg_r <= 1'b1;
    end
  end

  // report pacing: one at entry, then every rate_r seconds
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_r <= '0;
      sec_r <= 16'h0000;
      emerg_report_o <= 1'b0;
    end else begin
      emerg_report_o <= 1'b0;
      if (seq_done && !emerg_r) begin
        emerg_report_o <= 1'b1;
        sub_r <= '0;
        sec_r <= 16'h0000;
      end else if (emerg_r && tick) begin
        sub_r <= (sub_r == SW'(uic_pkg::SEC_T - 1)) ? '0 : sub_r + 1'b1;
        if (sub_r == SW'(uic_pkg::SEC_T - 1)) begin
          if (rate_r != 16'h0000 && sec_r + 16'h0001 >= rate_r) begin
            emerg_report_o <= 1'b1;
            sec_r <= 16'h0000;
          end else begin
            sec_r <= sec_r + 16'h0001;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // blink phase generators
  genvar gi;
  generate
    for (gi = 0; gi < uic_pkg::BLK_N; gi++) begin : g_blk
      logic [12:0] c_r;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          c_r <= 13'h0000;
        end else if (tick) begin
          c_r <= (c_r == 13'(uic_pkg::BLK_PER_MS[gi] - 1)) ?
                 13'h0000 : c_r + 13'h0001;
        end
      end
      assign ph[gi] = (c_r < 13'(uic_pkg::BLK_ON_MS[gi]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // charger connection chase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_d_r <= 1'b0;
      chg_act_r <= 1'b0;
      chg_cnt_r <= '0;
      stp_r <= '0;
      pos_r <= 2'h0;
    end else begin
      ext_d_r <= ext_power;
      if (ext_power && !ext_d_r && st_r != uic_pkg::UIC_OFF) begin
        chg_act_r <= 1'b1;
        chg_cnt_r <= CW'(uic_pkg::CHG_SEQ_T);
        stp_r <= '0;
        pos_r <= 2'h0;
      end else if (st_r == uic_pkg::UIC_OFF) begin
        chg_act_r <= 1'b0;
      end else if (chg_act_r && tick) begin
        chg_cnt_r <= chg_cnt_r - 1'b1;
        chg_act_r <= (chg_cnt_r != CW'(1));
        stp_r <= (stp_r == TW'(uic_pkg::CHG_STEP_T - 1)) ? '0 : stp_r + 1'b1;
        if (stp_r == TW'(uic_pkg::CHG_STEP_T - 1)) begin
          pos_r <= pos_r + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // led pattern selection
  always_comb begin
    led_nxt = 6'h00;
    case (st_r)
      uic_pkg::UIC_AWAKE: led_nxt[uic_pkg::LED_PWR] = 1'b1;
      uic_pkg::UIC_SLEEP: led_nxt[uic_pkg::LED_PWR] =
        emerg_r ? ph[uic_pkg::BLK_SLP_EM] : ph[uic_pkg::BLK_SLP];
      default: led_nxt[uic_pkg::LED_PWR] = 1'b0;
    endcase
    if (charging) begin
      led_nxt[uic_pkg::LED_BAT] = charge_done | ph[uic_pkg::BLK_BAT];
    end else begin
      case (battery_indicator_level)
        uic_pkg::BAT_REQ: led_nxt[uic_pkg::LED_BAT] = 1'b0;
        uic_pkg::BAT_LT20: led_nxt[uic_pkg::LED_BAT] =
          ph[uic_pkg::BLK_BAT_LO];
        uic_pkg::BAT_LT80: led_nxt[uic_pkg::LED_BAT] =
          ph[uic_pkg::BLK_BAT];
        default: led_nxt[uic_pkg::LED_BAT] = 1'b1;
      endcase
    end
    led_nxt[uic_pkg::LED_POS] = (fix_kind == uic_pkg::FIX_3D) ? 1'b1 :
      (fix_kind != 2'h0) & ph[uic_pkg::BLK_EVEN];
    led_nxt[uic_pkg::LED_WL] = link_r &
      (link_conn | ph[uic_pkg::BLK_EVEN]);
    led_nxt[uic_pkg::LED_REP] = (report_res == uic_pkg::REP_OK) |
      ((report_res == uic_pkg::REP_FAIL) & ph[uic_pkg::BLK_EVEN]);
    led_nxt[uic_pkg::LED_SIG] = (signal_bars >= uic_pkg::BARS_SOLID) |
      ((signal_bars != 3'h0) & ph[uic_pkg::BLK_EVEN]);
    if (st_r == uic_pkg::UIC_SLEEP) begin
      led_nxt[5:1] = 5'h00;
    end
    if (chg_act_r) begin
      led_nxt[uic_pkg::LED_BAT] = (pos_r == 2'h0);
      led_nxt[uic_pkg::LED_POS] = (pos_r == 2'h1);
      led_nxt[uic_pkg::LED_SIG] = (pos_r == 2'h2);
      led_nxt[uic_pkg::LED_REP] = (pos_r == 2'h3);
    end else if (emerg_r && st_r == uic_pkg::UIC_AWAKE) begin
      led_nxt = {6{ph[uic_pkg::BLK_EVEN]}};
    end
    if (st_r == uic_pkg::UIC_OFF) begin
      led_nxt = 6'h00;
    end
    led_nxt = led_nxt & led_en_r;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_o <= 6'h00;
      powered_o <= 1'b0;
      awake_o <= 1'b0;
      wireless_en_o <= 1'b0;
      emerg_flag_o <= 1'b0;
    end else begin
      led_o <= led_nxt;
      powered_o <= (st_r != uic_pkg::UIC_OFF);
      awake_o <= (st_r == uic_pkg::UIC_AWAKE);
      wireless_en_o <= link_r;
      emerg_flag_o <= emerg_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite register slave
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uic_pkg::RESP_OK;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == uic_pkg::ADDR_CTRL ||
                        aw_addr_r == uic_pkg::ADDR_RATE) ?
                       uic_pkg::RESP_OK : uic_pkg::RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_en_r <= uic_pkg::CTRL_RST;
      rate_r <= uic_pkg::RATE_RST;
    end else if (do_wr) begin
      if (aw_addr_r == uic_pkg::ADDR_CTRL && w_strb_r[0]) begin
        led_en_r <= w_data_r[5:0];
      end
      if (aw_addr_r == uic_pkg::ADDR_RATE) begin
        if (w_strb_r[0]) begin
          rate_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          rate_r[15:8] <= w_data_r[15:8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= uic_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= uic_pkg::RESP_OK;
      case (s_axi_araddr)
        uic_pkg::ADDR_CTRL: s_axi_rdata <= {26'h0000000, led_en_r};
        uic_pkg::ADDR_RATE: s_axi_rdata <= {16'h0000, rate_r};
        uic_pkg::ADDR_STAT: s_axi_rdata <= {22'h000000, led_o,
                                             link_r, emerg_r, st_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= uic_pkg::RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_long_power_off: assert property (
    pwr_ev.long_p && st_r == uic_pkg::UIC_AWAKE |=>
      st_r == uic_pkg::UIC_OFF ##1 !powered_o)
    else $error("long power press did not switch off");
  a_short_wake: assert property (
    pwr_ev.short_p && !wl_ev.short_p && st_r == uic_pkg::UIC_SLEEP |=>
      st_r == uic_pkg::UIC_AWAKE && wake_r == WW'(uic_pkg::WAKE_PWR_T))
    else $error("short power press did not wake for ten seconds");
  a_link_toggle: assert property (
    wl_ev.long_p && st_r == uic_pkg::UIC_AWAKE && !pwr_ev.long_p |=>
      link_r != $past(link_r) ##1 wireless_en_o == link_r)
    else $error("wireless long press did not toggle link");
  a_wl_wake: assert property (
    wl_ev.short_p && !pwr_ev.long_p && st_r == uic_pkg::UIC_SLEEP |=>
      wake_r == WW'(uic_pkg::WAKE_WL_T))
    else $error("wireless press did not wake for two minutes");
  a_seq_enter: assert property (
    wl_ev.short_p && seq_r == 2'h3 |=> emerg_r && st_r != uic_pkg::UIC_OFF)
    else $error("press sequence did not enter emergency");
  a_first_report: assert property (
    $rose(emerg_r) |-> emerg_report_o)
    else $error("no report at emergency entry");
  a_flag_on: assert property (
    emerg_r |=> emerg_flag_o)
    else $error("emergency flag missing");
  a_off_clears: assert property (
    st_r == uic_pkg::UIC_OFF |-> !emerg_r)
    else $error("emergency held while off");
  a_emerg_blink: assert property (
    emerg_r && st_r == uic_pkg::UIC_AWAKE && !chg_act_r |=>
      led_o == ($past(ph[uic_pkg::BLK_EVEN]) ? $past(led_en_r) : 6'h00))
    else $error("emergency led_enable_setting not blinking together");
  a_sleep_dark: assert property (
    st_r == uic_pkg::UIC_SLEEP && !chg_act_r |=> led_o[5:1] == 5'h00)
    else $error("led_enable_setting lit during sleep");
  a_awake_power: assert property (
    st_r == uic_pkg::UIC_AWAKE && led_en_r[uic_pkg::LED_PWR] &&
      !(emerg_r && !ph[uic_pkg::BLK_EVEN]) |=> led_o[uic_pkg::LED_PWR])
    else $error("power led not solid while awake");
  a_chase_start: assert property (
    $rose(ext_power) && st_r != uic_pkg::UIC_OFF |=> ##1 chg_act_r)
    else $error("charger chase did not start");
  a_mask_dark: assert property (
    led_en_r == 6'h00 |=> led_o == 6'h00)
    else $error("disabled led lit");
  a_off_dark: assert property (
    st_r == uic_pkg::UIC_OFF |=> led_o == 6'h00)
    else $error("led lit while off");

  c_emerg_entry: cover property ($rose(emerg_r));
  c_wl_wake: cover property (st_r == uic_pkg::UIC_SLEEP ##1
    wake_r == WW'(uic_pkg::WAKE_WL_T));
  c_chase_end: cover property ($fell(chg_act_r));
  c_repeat_report: cover property (emerg_r && emerg_report_o);
endmodule : uic_top

// File: verif/uic_user.sv
// user model pressing the power and wireless buttons
`timescale 1ns/100ps
module uic_user (
  input wire logic ref_clk,
  output logic pwr_btn_n,
  output logic wireless_link_button_n
);
  initial begin
    pwr_btn_n = 1'b1;
    wireless_link_button_n = 1'b1;
  end
  // hold one button for cyc cycles, release, then rest
  task press(input logic wl, input int cyc);
    @(posedge ref_clk);
    if (wl) wireless_link_button_n <= 1'b0;
    else pwr_btn_n <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
    pwr_btn_n <= 1'b1;
    wireless_link_button_n <= 1'b1;
    repeat (400) @(posedge ref_clk);
  endtask : press
endmodule : uic_user

// File: verif/tb.sv
// self-checking bench for the button and led controller
`timescale 1ns/100ps
module tb;
  localparam int TDIV = 4;
  localparam int LONG = 2100 * TDIV;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pwr_btn_n, wireless_link_button_n, charging, charge_done, link_conn;
  logic ext_power = 1'b0;
  logic sleep_req = 1'b0;
  logic [1:0] battery_indicator_level, fix_kind, report_res, resp;
  logic [2:0] signal_bars;
  logic [5:0] led_o, mask;
  logic powered_o, awake_o, wireless_en_o, emerg_flag_o, emerg_report_o;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata, rd;
  logic [31:0] seed = 32'h96A2E718;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0, comparisons = 0, cycles = 0, reports = 0, lit = 0;
  uic_top #(.TICK_DIV(TDIV)) dut (.*);
  uic_user usr (.ref_clk, .pwr_btn_n, .wireless_link_button_n);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task shuffle();
    seed = xs(seed);
    {link_conn, charging, charge_done, battery_indicator_level, fix_kind} <= seed[6:0];
    report_res <= seed[8:7];
    signal_bars <= 3'(seed[11:9] % 6);
  endtask : shuffle
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task nap();
    sleep_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sleep_req <= 1'b0;
  endtask : nap
  task wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (emerg_report_o === 1'b1) reports++;
    if (cycles == 80000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    shuffle();
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    axr(8'h00);
    chk({resp, rd}, {uic_pkg::RESP_OK, 26'h0, uic_pkg::CTRL_RST});
    axr(8'h04);
    chk({resp, rd}, {uic_pkg::RESP_OK, 16'h0, uic_pkg::RATE_RST});
    axr(8'h0C);
    chk({resp, rd}, {uic_pkg::RESP_ERR, 32'h0});
    chk(led_o, 6'h00);
    usr.press(1'b0, LONG);
    chk({powered_o, awake_o, led_o[0]}, 3'b111);
    usr.press(1'b1, LONG);
    chk(wireless_en_o, 1'b1);
    seed = xs(seed);
    mask = seed[5:0] & 6'h3E;
    axw(8'h00, {26'h0, mask});
    shuffle();
    repeat (8) @(posedge ref_clk);
    chk(led_o & ~mask, 6'h00);
    axw(8'h08, 32'h0);
    chk(resp, uic_pkg::RESP_ERR);
    axw(8'h00, 32'h3F);
    axw(8'h04, 32'h1);
    chk(resp, uic_pkg::RESP_OK);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      usr.press(i[0], (50 + int'(seed[8:0] % 450)) * TDIV);
    end
    chk({emerg_flag_o, 31'(reports)}, {1'b1, 31'h1});
    for (int i = 0; i < 8; i++) begin
      repeat (97 * TDIV) @(posedge ref_clk);
      chk(led_o == 6'h00 || led_o == 6'h3F, 1'b1);
      lit += int'(led_o == 6'h3F);
    end
    chk(lit > 0 && lit < 8, 1'b1);
    nap();
    chk({awake_o, led_o[5:1]}, 6'h00);
    usr.press(1'b0, 100 * TDIV);
    chk({awake_o, 31'(reports)}, {1'b1, 31'h2});
    axr(8'h08);
    chk(rd[3:0], 4'hE);
    usr.press(1'b0, LONG);
    chk({powered_o, emerg_flag_o, led_o}, 8'h00);
    usr.press(1'b0, LONG);
    chk({powered_o, emerg_flag_o}, 2'b10);
    {link_conn, charging, charge_done, battery_indicator_level, fix_kind} <= 7'h0F;
    report_res <= 2'h2;
    signal_bars <= 3'h5;
    ext_power <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(led_o, 6'h03);
    repeat (1100) @(posedge ref_clk);
    chk(led_o, 6'h05);
    repeat (11500) @(posedge ref_clk);
    chk(led_o, 6'h37);
    nap();
    chk(awake_o, 1'b0);
    usr.press(1'b1, 100 * TDIV);
    chk(awake_o, 1'b1);
    wrap_up();
  end
endmodule : tb
